// File: core/supply_integrity_consts.svh
`ifndef SUPPLY_INTEGRITY_CONSTS_SVH
`define SUPPLY_INTEGRITY_CONSTS_SVH

// Register addresses on the byte-wide register port
`define ADDR_INTEGRITY 8'h3A
`define ADDR_EVENT 8'h3B
`define ADDR_EVENT_MASK 8'h3C
`define ADDR_CAUSE 8'h3D

// Field positions in integrity_control_status
`define BIT_IRQ_EN 0
`define BIT_WARN 1
`define BIT_UV_FLAG 2
`define BIT_LOCK 3

// Field positions in the event status and mask registers
`define EV_WARN 0
`define EV_UV_RESET 1
`define EV_UNLOCK 2
`define EV_WATCHDOG 3
`define EVENT_W 4

// Field position in the reset cause register
`define BIT_WDG_FLAG 0

// Reset values
`define INTEGRITY_RESET 8'h00
`define EVENT_RESET 4'h0
`define MASK_RESET 4'h0
`define RDATA_IDLE 8'h00

`endif

// File: core/supply_integrity_monitor.sv
`timescale 1ns/10ps
`include "supply_integrity_consts.svh"

module supply_integrity_monitor
  import supply_integrity_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Analog detector outputs, asynchronous
  input wire logic uv_low_i,
  input wire logic warn_cmp_i,
  input wire logic pll_lock_i,
  // Option settings, static
  input wire logic detector_enable_i,
  input wire logic [1:0] threshold_sel_i,
  // Other reset sources, one-cycle pulses on clk_i
  input wire logic watchdog_reset_i,
  input wire logic ext_reset_i,
  // Core power mode and interrupt acknowledge
  input wire logic wait_mode_i,
  input wire logic halt_mode_i,
  input wire logic warn_irq_ack_i,
  // Reset outputs, reset pin is open drain
  output logic chip_reset_o,
  output logic reset_pin_o,
  output logic reset_pin_oe_o,
  // Detector configuration to the analog side
  output logic detector_enable_o,
  output logic [1:0] threshold_o,
  // Interrupts and wake
  output logic warn_irq_o,
  output logic wake_o,
  output logic event_irq_o
);

  // Two-stage synchronisers for the analog comparators and the lock
  logic [2:0] sync_meta;
  logic [2:0] sync_q;
  logic sync_uv;
  logic sync_warn;
  logic sync_lock;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_meta <= 3'h0;
      sync_q <= 3'h0;
    end else begin
      sync_meta <= {pll_lock_i, warn_cmp_i, uv_low_i};
      sync_q <= sync_meta;
    end
  end

  assign sync_uv = sync_q[0];
  assign sync_warn = sync_q[1];
  assign sync_lock = sync_q[2];

  // Option capture; the strap is caught by a clock edge after release
  cfg_state_t cfg_state;
  cfg_state_t next_cfg_state;
  logic opt_enable;
  logic next_opt_enable;
  threshold_t opt_threshold;
  threshold_t next_opt_threshold;

  always_comb begin
    next_cfg_state = cfg_state;
    next_opt_enable = opt_enable;
    next_opt_threshold = opt_threshold;
    case (cfg_state)
      CFG_CAPTURE: begin
        next_opt_enable = detector_enable_i;
        case (threshold_sel_i)
          2'h1: next_opt_threshold = THR_MEDIUM;
          2'h2: next_opt_threshold = THR_HIGH;
          default: next_opt_threshold = THR_LOW; // Unused code falls back to low
        endcase
        next_cfg_state = CFG_RUN;
      end
      CFG_RUN: begin
        next_cfg_state = CFG_RUN; // Held until the next reset
      end
      default: begin
        next_cfg_state = CFG_CAPTURE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_state <= CFG_CAPTURE;
      opt_enable <= 1'b0;
      opt_threshold <= THR_LOW;
    end else begin
      cfg_state <= next_cfg_state;
      opt_enable <= next_opt_enable;
      opt_threshold <= next_opt_threshold;
    end
  end

  // Qualified detector levels; nothing is trusted until options are in
  logic uv_active;
  logic warn_live;
  logic system_reset;

  assign uv_active = opt_enable & sync_uv;
  assign warn_live = opt_enable & sync_warn;
  assign system_reset = uv_active | watchdog_reset_i | ext_reset_i;

  // Register port decode; writes are ignored in halt since state is frozen
  logic wr_integrity;
  logic wr_mask;
  logic wr_cause;
  logic rd_event;
  logic wdata_irq_en;

  assign wr_integrity = wr_i & ~halt_mode_i & (addr_i == `ADDR_INTEGRITY);
  assign wr_mask = wr_i & ~halt_mode_i & (addr_i == `ADDR_EVENT_MASK);
  assign wr_cause = wr_i & ~halt_mode_i & (addr_i == `ADDR_CAUSE);
  assign rd_event = rd_i & (addr_i == `ADDR_EVENT);
  assign wdata_irq_en = wdata_i[`BIT_IRQ_EN];

  // Integrity state, flags and interrupt pending
  logic ctl_irq_en;
  logic next_ctl_irq_en;
  logic warn_status;
  logic next_warn_status;
  logic lock_status;
  logic next_lock_status;
  logic uv_flag;
  logic next_uv_flag;
  logic wdg_flag;
  logic next_wdg_flag;
  logic uv_active_q;
  logic next_warn_pending;
  logic warn_toggle;
  logic warn_set;

  always_comb begin
    // Halt freezes the visible copies; the comparator keeps running
    next_warn_status = halt_mode_i ? warn_status : warn_live;
    next_lock_status = halt_mode_i ? lock_status : sync_lock;
    warn_toggle = next_warn_status != warn_status;
    // Both edges of the warning count, gated by the enable bit
    warn_set = warn_toggle & ctl_irq_en & ~system_reset;

    next_ctl_irq_en = ctl_irq_en;
    if (system_reset) begin
      next_ctl_irq_en = 1'b0;
    end else if (wr_integrity) begin
      next_ctl_irq_en = wdata_irq_en;
    end

    // A new toggle beats an acknowledge in the same cycle
    next_warn_pending = warn_irq_o;
    if (system_reset) begin
      next_warn_pending = 1'b0;
    end else if (warn_set) begin
      next_warn_pending = 1'b1;
    end else if (warn_irq_ack_i) begin
      next_warn_pending = 1'b0;
    end

    // Other reset kinds do not touch this flag
    next_uv_flag = uv_flag;
    if (uv_active) begin
      next_uv_flag = 1'b1;
    end else if (wr_integrity && !wdata_i[`BIT_UV_FLAG]) begin
      next_uv_flag = 1'b0;
    end

    // Undervoltage has priority and wipes the watchdog trace
    next_wdg_flag = wdg_flag;
    if (uv_active) begin
      next_wdg_flag = 1'b0;
    end else if (watchdog_reset_i) begin
      next_wdg_flag = 1'b1;
    end else if (wr_cause && !wdata_i[`BIT_WDG_FLAG]) begin
      next_wdg_flag = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_irq_en <= 1'b0;
      warn_status <= 1'b0;
      lock_status <= 1'b0;
      uv_flag <= 1'b0;
      wdg_flag <= 1'b0;
      uv_active_q <= 1'b0;
      warn_irq_o <= 1'b0;
    end else begin
      ctl_irq_en <= next_ctl_irq_en;
      warn_status <= next_warn_status;
      lock_status <= next_lock_status;
      uv_flag <= next_uv_flag;
      wdg_flag <= next_wdg_flag;
      uv_active_q <= uv_active;
      warn_irq_o <= next_warn_pending;
    end
  end

  // Sticky event status, cleared by reading it; a new event wins the clear
  logic [`EVENT_W-1:0] event_status;
  logic [`EVENT_W-1:0] next_event_status;
  logic [`EVENT_W-1:0] event_mask;
  logic [`EVENT_W-1:0] next_event_mask;
  logic [`EVENT_W-1:0] event_set;

  always_comb begin
    event_set = `EVENT_RESET;
    event_set[`EV_WARN] = warn_toggle;
    event_set[`EV_UV_RESET] = uv_active & ~uv_active_q;
    event_set[`EV_UNLOCK] = lock_status & ~next_lock_status;
    event_set[`EV_WATCHDOG] = watchdog_reset_i & ~uv_active;
    next_event_status = (rd_event ? `EVENT_RESET : event_status) | event_set;
    next_event_mask = wr_mask ? wdata_i[`EVENT_W-1:0] : event_mask;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      event_status <= `EVENT_RESET;
      event_mask <= `MASK_RESET;
    end else begin
      event_status <= next_event_status;
      event_mask <= next_event_mask;
    end
  end

  // Read mux; data stand only in the cycle after the strobe
  logic [7:0] integrity_view;
  logic [7:0] next_rdata;

  always_comb begin
    integrity_view = `INTEGRITY_RESET; // Reserved bits stay zero
    integrity_view[`BIT_IRQ_EN] = ctl_irq_en;
    integrity_view[`BIT_WARN] = warn_status;
    integrity_view[`BIT_UV_FLAG] = uv_flag;
    integrity_view[`BIT_LOCK] = lock_status;
    next_rdata = `RDATA_IDLE;
    if (rd_i) begin
      case (addr_i)
        `ADDR_INTEGRITY: next_rdata = integrity_view;
        `ADDR_EVENT: next_rdata = {4'h0, event_status};
        `ADDR_EVENT_MASK: next_rdata = {4'h0, event_mask};
        `ADDR_CAUSE: next_rdata = {7'h00, wdg_flag};
        default: next_rdata = `RDATA_IDLE; // Unmapped reads return zero
      endcase
    end
  end

  // Output registers; the reset pin only ever drives low
  logic next_wake;
  logic next_event_irq;

  always_comb begin
    // Halt wake is left to other sources
    next_wake = next_warn_pending & wait_mode_i & ~halt_mode_i;
    next_event_irq = |(next_event_status & next_event_mask);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= `RDATA_IDLE;
      chip_reset_o <= 1'b0;
      reset_pin_o <= 1'b0;
      reset_pin_oe_o <= 1'b0;
      detector_enable_o <= 1'b0;
      threshold_o <= THR_LOW;
      wake_o <= 1'b0;
      event_irq_o <= 1'b0;
    end else begin
      rdata_o <= next_rdata;
      chip_reset_o <= uv_active;
      reset_pin_o <= 1'b0;
      reset_pin_oe_o <= uv_active;
      detector_enable_o <= next_opt_enable;
      threshold_o <= next_opt_threshold;
      wake_o <= next_wake;
      event_irq_o <= next_event_irq;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_quiet_run;
    (opt_enable && !halt_mode_i) [*2];
  endsequence

  sequence s_armed_toggle;
    (ctl_irq_en && !system_reset) ##1 $changed(warn_status);
  endsequence

  a_uv_holds_reset: assert property (uv_active |=> chip_reset_o && reset_pin_oe_o && !reset_pin_o)
    else $error("undervoltage did not hold reset");
  a_option_static: assert property ((cfg_state == CFG_RUN) |=> $stable(opt_enable) && $stable(opt_threshold))
    else $error("option configuration changed while running");
  a_uv_clears_wdg: assert property (uv_active |=> !wdg_flag)
    else $error("watchdog flag survived undervoltage");
  a_warn_copy: assert property (s_quiet_run |=> warn_status == $past(warn_cmp_i, 3))
    else $error("warning status does not follow comparator");
  a_warn_gated: assert property (!opt_enable |-> !warn_status && !warn_irq_o)
    else $error("warning active with detector disabled");
  a_toggle_irq: assert property (s_armed_toggle |-> warn_irq_o)
    else $error("warning toggle raised no request");
  a_ack_clears: assert property (warn_irq_o && warn_irq_ack_i && !warn_set && !system_reset |=> !warn_irq_o)
    else $error("acknowledge did not clear request");
  a_no_enable_irq: assert property (!warn_irq_o && !ctl_irq_en |=> !warn_irq_o)
    else $error("request raised without enable");
  a_wake_wait: assert property (warn_irq_o && wait_mode_i && !halt_mode_i && !warn_irq_ack_i && !system_reset |=> wake_o)
    else $error("pending request did not wake from wait");
  a_halt_freeze: assert property (halt_mode_i && !system_reset |=> $stable(warn_status) && $stable(ctl_irq_en) && !wake_o)
    else $error("halt did not freeze integrity state");

  a_lock_track: assert property ((!halt_mode_i) [*2] |=> lock_status == $past(pll_lock_i, 3))
    else $error("lock bit does not follow loop");

  a_uv_sets_flag: assert property (uv_active |=> uv_flag)
    else $error("undervoltage flag not set");

  a_flag_keeps: assert property (uv_flag && (watchdog_reset_i || ext_reset_i) && !wr_integrity |=> uv_flag)
    else $error("other reset cleared undervoltage flag");

  a_reserved_zero: assert property ($past(rd_i) |-> rdata_o[7:4] == 4'h0)
    else $error("reserved bits read nonzero");

  a_rdata_slot: assert property (!$past(rd_i) |-> rdata_o == `RDATA_IDLE)
    else $error("read data outside its cycle");

  a_enable_write: assert property (wr_integrity && !system_reset |=> ctl_irq_en == $past(wdata_irq_en))
    else $error("enable bit write not taken");

  a_event_wins: assert property (warn_toggle && rd_event |=> event_status[`EV_WARN])
    else $error("read clear lost a warning event");

endmodule : supply_integrity_monitor

// File: core/supply_integrity_pkg.sv
package supply_integrity_pkg;

  // Detector threshold chosen by the option setting
  typedef enum logic [1:0] {
    THR_LOW = 2'b00,
    THR_MEDIUM = 2'b01,
    THR_HIGH = 2'b10
  } threshold_t;

  // Option capture sequence after reset release
  typedef enum logic [1:0] {
    CFG_CAPTURE = 2'b01,
    CFG_RUN = 2'b10
  } cfg_state_t;

endpackage : supply_integrity_pkg

// File: tb/core_irq_model.sv
`timescale 1ns/10ps

module core_irq_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request from the block, core mask, service latency
  input wire logic irq_i,
  input wire logic global_mask_i,
  input wire logic [3:0] delay_i,
  // Service routine entry
  output logic ack_o
);
  logic [3:0] wait_cnt;

  // Latency to vector fetch; a slow core holds the request pending longer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_cnt <= 4'h0;
      ack_o <= 1'b0;
    end else if (ack_o) begin
      ack_o <= 1'b0; // One-cycle entry pulse
      wait_cnt <= 4'h0;
    end else if (irq_i && !global_mask_i) begin // Masked core never enters
      if (wait_cnt >= delay_i) begin
        ack_o <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end else begin
      wait_cnt <= 4'h0;
    end
  end
endmodule : core_irq_model

// File: tb/supply_integrity_monitor_tb.sv
`timescale 1ns/10ps

module supply_integrity_monitor_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic uv_low_i = 1'b0;
  logic warn_cmp_i = 1'b0;
  logic pll_lock_i = 1'b0;
  logic detector_enable_i = 1'b1;
  logic [1:0] threshold_sel_i = 2'b00;
  logic watchdog_reset_i = 1'b0;
  logic ext_reset_i = 1'b0;
  logic wait_mode_i = 1'b0;
  logic halt_mode_i = 1'b0;
  logic ack;
  logic mask = 1'b1;
  logic [3:0] delay = 4'h3;
  logic [7:0] rdata_o;
  logic chip_reset_o, reset_pin_o, reset_pin_oe_o, detector_enable_o;
  logic [1:0] threshold_o;
  logic warn_irq_o, wake_o, event_irq_o;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;

  // 100 ns clock
  always #50 clk_i = ~clk_i;

  supply_integrity_monitor i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .uv_low_i(uv_low_i), .warn_cmp_i(warn_cmp_i),
    .pll_lock_i(pll_lock_i), .detector_enable_i(detector_enable_i), .threshold_sel_i(threshold_sel_i),
    .watchdog_reset_i(watchdog_reset_i), .ext_reset_i(ext_reset_i), .wait_mode_i(wait_mode_i),
    .halt_mode_i(halt_mode_i), .warn_irq_ack_i(ack), .chip_reset_o(chip_reset_o),
    .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o), .detector_enable_o(detector_enable_o),
    .threshold_o(threshold_o), .warn_irq_o(warn_irq_o), .wake_o(wake_o), .event_irq_o(event_irq_o));

  // Core side acks the warning request
  core_irq_model i_core (.clk_i(clk_i), .rst_i(rst_i), .irq_i(warn_irq_o), .global_mask_i(mask),
    .delay_i(delay), .ack_o(ack));

  task automatic final_report;
    $display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // Hang guard, over ten times the expected run length
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Bus cycles start right after an edge; the trailing edge keeps strobes from doubling up
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    tick(1);
    wr_i <= 1'b0;
    tick(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    tick(1);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    tick(1);
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk($sformatf("reg %h", a), exp, d);
  endtask : rdchk

  // Options only change under reset
  task automatic do_reset(input logic en, input logic [1:0] thr);
    rst_i <= 1'b1;
    detector_enable_i <= en;
    threshold_sel_i <= thr;
    tick(10);
    rst_i <= 1'b0;
    tick(3);
  endtask : do_reset

  task automatic t_options;
    for (int t = 0; t < 3; t++) begin
      do_reset(1'b1, 2'(t));
      chk("threshold", 8'(t), {6'h00, threshold_o});
      chk("det_en", 8'h01, {7'h00, detector_enable_o});
      rdchk(8'h3A, 8'h00);
    end
    rdchk(8'h40, 8'h00);
  endtask : t_options

  task automatic t_lock;
    pll_lock_i <= 1'b1;
    tick(4);
    rdchk(8'h3A, 8'h08);
    pll_lock_i <= 1'b0;
    tick(4);
    rdchk(8'h3A, 8'h00);
    rdchk(8'h3B, 8'h04); // Loss of lock leaves a sticky event
  endtask : t_lock

  // Both edges request; slow core first, then a prompt one
  task automatic t_warn;
    wr(8'h3A, 8'h01);
    rdchk(8'h3A, 8'h01);
    for (int e = 0; e < 2; e++) begin
      mask <= 1'b1;
      warn_cmp_i <= ~warn_cmp_i;
      tick(4);
      chk("warn_irq", 8'h01, {7'h00, warn_irq_o});
      rdchk(8'h3A, e ? 8'h01 : 8'h03);
      mask <= 1'b0;
      delay <= e ? 4'h0 : 4'h3;
      tick(8);
      chk("warn_irq", 8'h00, {7'h00, warn_irq_o});
    end
    wr(8'h3A, 8'h00);
    warn_cmp_i <= 1'b1;
    tick(4);
    chk("warn_irq", 8'h00, {7'h00, warn_irq_o});
    rdchk(8'h3A, 8'h02);
    warn_cmp_i <= 1'b0;
    tick(4);
  endtask : t_warn

  task automatic t_events;
    logic [7:0] d;
    rd(8'h3B, d);
    wr(8'h3C, 8'h01);
    rdchk(8'h3C, 8'h01);
    warn_cmp_i <= 1'b1;
    tick(4);
    chk("event_irq", 8'h01, {7'h00, event_irq_o});
    rdchk(8'h3B, 8'h01);
    tick(2);
    chk("event_irq", 8'h00, {7'h00, event_irq_o});
    wr(8'h3C, 8'h00);
    warn_cmp_i <= 1'b0;
    tick(4);
    chk("event_irq", 8'h00, {7'h00, event_irq_o});
  endtask : t_events

  // Wait wakes on a warning, halt freezes the register and never wakes
  task automatic t_modes;
    wr(8'h3A, 8'h01);
    mask <= 1'b1;
    wait_mode_i <= 1'b1;
    warn_cmp_i <= 1'b1;
    tick(5);
    chk("wake", 8'h01, {7'h00, wake_o});
    wait_mode_i <= 1'b0;
    mask <= 1'b0;
    tick(8);
    halt_mode_i <= 1'b1;
    mask <= 1'b1;
    warn_cmp_i <= 1'b0;
    tick(5);
    chk("wake", 8'h00, {7'h00, wake_o});
    wr(8'h3A, 8'h00);
    rdchk(8'h3A, 8'h03);
    halt_mode_i <= 1'b0;
    tick(4);
    mask <= 1'b0;
    tick(8);
    rdchk(8'h3A, 8'h01);
  endtask : t_modes

  task automatic t_uv;
    rdchk(8'h3B, 8'h01); // Only warning toggles are left from the mode test
    watchdog_reset_i <= 1'b1;
    tick(1);
    watchdog_reset_i <= 1'b0;
    tick(2);
    rdchk(8'h3D, 8'h01);
    uv_low_i <= 1'b1;
    tick(4);
    chk("chip_reset", 8'h01, {7'h00, chip_reset_o});
    chk("pin_oe", 8'h01, {7'h00, reset_pin_oe_o});
    chk("pin", 8'h00, {7'h00, reset_pin_o});
    uv_low_i <= 1'b0;
    tick(4);
    chk("chip_reset", 8'h00, {7'h00, chip_reset_o});
    rdchk(8'h3A, 8'h04);
    rdchk(8'h3D, 8'h00);
    watchdog_reset_i <= 1'b1;
    ext_reset_i <= 1'b1;
    tick(1);
    watchdog_reset_i <= 1'b0;
    ext_reset_i <= 1'b0;
    tick(2);
    rdchk(8'h3A, 8'h04);
    wr(8'h3A, 8'h04);
    rdchk(8'h3A, 8'h04);
    wr(8'h3A, 8'h00);
    rdchk(8'h3A, 8'h00);
    rdchk(8'h3B, 8'h0A); // Watchdog and undervoltage start events
  endtask : t_uv

  // Detector off by option: no warning path, no undervoltage reset
  task automatic t_disabled;
    logic [7:0] d;
    do_reset(1'b0, 2'b00);
    chk("det_en", 8'h00, {7'h00, detector_enable_o});
    wr(8'h3A, 8'h01);
    warn_cmp_i <= 1'b1;
    uv_low_i <= 1'b1;
    tick(4);
    rd(8'h3A, d);
    chk("reg 3A", 8'h01, d & 8'hFB);
    chk("warn_irq", 8'h00, {7'h00, warn_irq_o});
    chk("chip_reset", 8'h00, {7'h00, chip_reset_o});
    warn_cmp_i <= 1'b0;
    uv_low_i <= 1'b0;
    tick(4);
  endtask : t_disabled

  initial begin
    t_options();
    t_lock();
    t_warn();
    t_events();
    t_modes();
    t_uv();
    t_disabled();
    final_report();
  end
endmodule : supply_integrity_monitor_tb
